//--- tap_scan_map.vh
`ifndef TAP_SCAN_MAP_VH
`define TAP_SCAN_MAP_VH

// ----------------------------------------
// Controller states
// ----------------------------------------
`define TAP_ST_RESET 4'h0
`define TAP_ST_IDLE 4'h1
`define TAP_ST_SEL_DR 4'h2
`define TAP_ST_CAP_DR 4'h3
`define TAP_ST_SH_DR 4'h4
`define TAP_ST_EX1_DR 4'h5
`define TAP_ST_PAU_DR 4'h6
`define TAP_ST_EX2_DR 4'h7
`define TAP_ST_UPD_DR 4'h8
`define TAP_ST_SEL_IR 4'h9
`define TAP_ST_CAP_IR 4'ha
`define TAP_ST_SH_IR 4'hb
`define TAP_ST_EX1_IR 4'hc
`define TAP_ST_PAU_IR 4'hd
`define TAP_ST_EX2_IR 4'he
`define TAP_ST_UPD_IR 4'hf

// ----------------------------------------
// Instruction register and codes
// ----------------------------------------
`define TAP_IR_LEN 10
`define TAP_IR_CAPTURE 10'h001
`define TAP_INS_EXTEST 10'h000
`define TAP_INS_RECONFIG_PULSE 10'h001
`define TAP_INS_CIRCUIT_RECONFIG 10'h002
`define TAP_INS_SAMPLE 10'h005
`define TAP_INS_IDCODE 10'h006
`define TAP_INS_USERCODE 10'h007
`define TAP_INS_CLAMP 10'h00a
`define TAP_INS_HIGHZ 10'h00b
`define TAP_INS_CONFIG_IO 10'h00d
`define TAP_INS_ANALYZER 10'h00e
`define TAP_INS_BYPASS 10'h3ff

// ----------------------------------------
// Data register sizes and reset values
// ----------------------------------------
`define TAP_CODE_LEN 32
`define TAP_CFG_BYTE_LEN 8
`define TAP_BSR_LEN_DEF 1029
`define TAP_IO_NUM_DEF 343
`define TAP_IOSTD_LEN_DEF 64
`define TAP_USERCODE_DEF 32'hffff_ffff

`endif

//--- tap_scan_port.v
`timescale 1ns/1ps
`include "tap_scan_map.vh"

// Overview of operation
// - Sample/preload snapshots pin states and preloads a pattern for later output.
// - External test drives pins from the scan pattern and captures input pins.
// - Bypass puts a one-bit register between TDI and TDO.
// - User code instruction shifts out a 32-bit user code register.
// - Identification instruction shifts out the identification code register.
// - High-impedance instruction uses bypass and floats every I/O pin.
// - Clamp uses bypass and holds pins at boundary register values.
// - In-circuit reconfiguration instruction loads configuration data through the port.
// - Reconfiguration pulse acts like the request pin going low, pin untouched.
// - I/O configuration instruction programs element standards, before or after configuration.
// - I/O configuration during configuration aborts that configuration.
// - Analyzer instruction lets an embedded analyzer use the scan port.
// - Bus hold or weak pull-up overrides the floating state of test modes.
// - Instruction register is ten bits; user code register thirty-two bits.
// - Boundary register length is a parameter: 1029, 1665 or 1941 cells.
// - Identification code: version 4, part 16, maker 11, one final bit.
// - Identification code least significant bit always reads one.
module tap_scan_port #(
  parameter BSR_LEN = `TAP_BSR_LEN_DEF,
  parameter IO_NUM = `TAP_IO_NUM_DEF,
  parameter IOSTD_LEN = `TAP_IOSTD_LEN_DEF,
  parameter [31:0] USER_CODE = `TAP_USERCODE_DEF,
  parameter [3:0] ID_VERSION = 4'h1, // Arbitrary value.
  parameter [15:0] ID_PART = 16'h1234, // Arbitrary value.
  parameter [10:0] ID_MAKER = 11'h155 // Arbitrary value.
) (
  input wire ref_clk,
  input wire reset,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  input wire [IO_NUM-1:0] pin_in,
  input wire [IO_NUM-1:0] core_out,
  input wire [IO_NUM-1:0] core_oe,
  input wire [IO_NUM-1:0] keep_en,
  output reg [IO_NUM-1:0] pin_out,
  output reg [IO_NUM-1:0] pin_oe,
  output reg [IO_NUM-1:0] pin_keep,
  input wire config_request_pin_n,
  input wire config_busy,
  output reg config_restart,
  output reg config_abort,
  output reg [7:0] cfg_byte,
  output reg cfg_byte_valid,
  output reg [IOSTD_LEN-1:0] iostd_cfg,
  input wire analyzer_tdo,
  output reg analyzer_sel,
  output reg analyzer_tdi,
  output reg analyzer_capture,
  output reg analyzer_shift,
  output reg analyzer_update
);

  // ----------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------
  reg tck_s1;
  reg tck_s2;
  reg tck_s3;
  reg tms_s1;
  reg tms_s2;
  reg tdi_s1;
  reg tdi_s2;
  reg req_s1;
  reg req_s2;
  reg req_s3;
  reg [IO_NUM-1:0] pin_s1;
  reg [IO_NUM-1:0] pin_s2;
  wire tck_rise;
  wire tck_fall;

  // Every pin input goes through two flops before anything reads it.
  always @(posedge ref_clk) begin
    if (reset) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
      req_s3 <= 1'b1;
      pin_s1 <= {IO_NUM{1'b0}};
      pin_s2 <= {IO_NUM{1'b0}};
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
      req_s1 <= config_request_pin_n;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // Edges are found from the second and third stages only.
  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;

  // ----------------------------------------
  // Controller state machine
  // ----------------------------------------
  reg [3:0] state;
  reg [3:0] next_state;

  // Standard sixteen-state walk steered by TMS at each rising TCK.
  always @* begin
    case (state)
      `TAP_ST_RESET: next_state = tms_s2 ? `TAP_ST_RESET : `TAP_ST_IDLE;
      `TAP_ST_IDLE: next_state = tms_s2 ? `TAP_ST_SEL_DR : `TAP_ST_IDLE;
      `TAP_ST_SEL_DR: next_state = tms_s2 ? `TAP_ST_SEL_IR : `TAP_ST_CAP_DR;
      `TAP_ST_CAP_DR: next_state = tms_s2 ? `TAP_ST_EX1_DR : `TAP_ST_SH_DR;
      `TAP_ST_SH_DR: next_state = tms_s2 ? `TAP_ST_EX1_DR : `TAP_ST_SH_DR;
      `TAP_ST_EX1_DR: next_state = tms_s2 ? `TAP_ST_UPD_DR : `TAP_ST_PAU_DR;
      `TAP_ST_PAU_DR: next_state = tms_s2 ? `TAP_ST_EX2_DR : `TAP_ST_PAU_DR;
      `TAP_ST_EX2_DR: next_state = tms_s2 ? `TAP_ST_UPD_DR : `TAP_ST_SH_DR;
      `TAP_ST_UPD_DR: next_state = tms_s2 ? `TAP_ST_SEL_DR : `TAP_ST_IDLE;
      `TAP_ST_SEL_IR: next_state = tms_s2 ? `TAP_ST_RESET : `TAP_ST_CAP_IR;
      `TAP_ST_CAP_IR: next_state = tms_s2 ? `TAP_ST_EX1_IR : `TAP_ST_SH_IR;
      `TAP_ST_SH_IR: next_state = tms_s2 ? `TAP_ST_EX1_IR : `TAP_ST_SH_IR;
      `TAP_ST_EX1_IR: next_state = tms_s2 ? `TAP_ST_UPD_IR : `TAP_ST_PAU_IR;
      `TAP_ST_PAU_IR: next_state = tms_s2 ? `TAP_ST_EX2_IR : `TAP_ST_PAU_IR;
      `TAP_ST_EX2_IR: next_state = tms_s2 ? `TAP_ST_UPD_IR : `TAP_ST_SH_IR;
      `TAP_ST_UPD_IR: next_state = tms_s2 ? `TAP_ST_SEL_DR : `TAP_ST_IDLE;
      default: next_state = `TAP_ST_RESET;
    endcase
  end

  // The state only moves on a TCK rise, so a stopped TCK freezes it.
  always @(posedge ref_clk) begin
    if (reset) begin
      state <= `TAP_ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  wire cap_dr = tck_rise & (state == `TAP_ST_CAP_DR);
  wire sh_dr = tck_rise & (state == `TAP_ST_SH_DR);
  wire upd_dr = tck_fall & (state == `TAP_ST_UPD_DR);
  wire upd_ir = tck_fall & (state == `TAP_ST_UPD_IR);

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  reg [`TAP_IR_LEN-1:0] ir_sh;
  reg [`TAP_IR_LEN-1:0] ir;

  // Shift stage captures the fixed pattern; the active code changes on update.
  always @(posedge ref_clk) begin
    if (reset) begin
      ir_sh <= `TAP_IR_CAPTURE;
      ir <= `TAP_INS_IDCODE;
    end else begin
      if (tck_rise && state == `TAP_ST_CAP_IR) begin
        ir_sh <= `TAP_IR_CAPTURE;
      end else if (tck_rise && state == `TAP_ST_SH_IR) begin
        ir_sh <= {tdi_s2, ir_sh[`TAP_IR_LEN-1:1]};
      end
      if (tck_fall && state == `TAP_ST_RESET) begin
        ir <= `TAP_INS_IDCODE;
      end else if (upd_ir) begin
        ir <= ir_sh;
      end
    end
  end

  wire ins_extest = (ir == `TAP_INS_EXTEST);
  wire ins_sample = (ir == `TAP_INS_SAMPLE);
  wire ins_clamp = (ir == `TAP_INS_CLAMP);
  wire ins_highz = (ir == `TAP_INS_HIGHZ);
  wire ins_bsr = ins_extest | ins_sample;
  wire ins_code = (ir == `TAP_INS_IDCODE) | (ir == `TAP_INS_USERCODE);
  wire ins_cfg = (ir == `TAP_INS_CIRCUIT_RECONFIG);
  wire ins_iostd = (ir == `TAP_INS_CONFIG_IO);
  wire ins_anl = (ir == `TAP_INS_ANALYZER);

  // ----------------------------------------
  // Boundary register
  // ----------------------------------------
  reg [BSR_LEN-1:0] bsr_sh;
  reg [IO_NUM-1:0] bsr_out;
  reg [IO_NUM-1:0] bsr_oe;
  wire [BSR_LEN-1:0] bsr_cap;

  // Cells are inputs, then output data, then output enables; spares read zero.
  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_cell
      if (gi < IO_NUM) begin : g_in
        assign bsr_cap[gi] = pin_s2[gi];
      end else if (gi < 2 * IO_NUM) begin : g_out
        assign bsr_cap[gi] = pin_out[gi - IO_NUM];
      end else if (gi < 3 * IO_NUM) begin : g_oe
        assign bsr_cap[gi] = pin_oe[gi - 2 * IO_NUM];
      end else begin : g_pad
        assign bsr_cap[gi] = 1'b0;
      end
    end
  endgenerate

  // Capture takes what the pins really show, so a sample never disturbs them.
  always @(posedge ref_clk) begin
    if (reset) begin
      bsr_sh <= {BSR_LEN{1'b0}};
      bsr_out <= {IO_NUM{1'b0}};
      bsr_oe <= {IO_NUM{1'b0}};
    end else begin
      if (cap_dr && ins_bsr) begin
        bsr_sh <= bsr_cap;
      end else if (sh_dr && ins_bsr) begin
        bsr_sh <= {tdi_s2, bsr_sh[BSR_LEN-1:1]};
      end
      if (upd_dr && ins_bsr) begin
        bsr_out <= bsr_sh[2*IO_NUM-1:IO_NUM];
        bsr_oe <= bsr_sh[3*IO_NUM-1:2*IO_NUM];
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire test_drive = ins_extest | ins_clamp;

  // Clamp keeps the last update; a new preload under clamp cannot reach pins.
  always @(posedge ref_clk) begin
    if (reset) begin
      pin_out <= {IO_NUM{1'b0}};
      pin_oe <= {IO_NUM{1'b0}};
      pin_keep <= {IO_NUM{1'b0}};
    end else begin
      pin_out <= test_drive ? bsr_out : core_out;
      if (ins_highz) begin
        pin_oe <= {IO_NUM{1'b0}};
      end else begin
        pin_oe <= test_drive ? bsr_oe : core_oe;
      end
      if (ins_highz) begin
        pin_keep <= keep_en;
      end else if (test_drive) begin
        pin_keep <= keep_en & ~bsr_oe;
      end else begin
        pin_keep <= {IO_NUM{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // Bypass, code and setup registers
  // ----------------------------------------
  reg bypass;
  reg [`TAP_CODE_LEN-1:0] code_sh;
  reg [IOSTD_LEN-1:0] iostd_sh;
  reg [7:0] cfg_sh;
  reg [2:0] cfg_cnt;
  wire [`TAP_CODE_LEN-1:0] id_code = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Bypass captures zero; it serves every code that selects no other path.
  always @(posedge ref_clk) begin
    if (reset) begin
      bypass <= 1'b0;
      code_sh <= {`TAP_CODE_LEN{1'b0}};
    end else begin
      if (cap_dr) begin
        bypass <= 1'b0;
      end else if (sh_dr) begin
        bypass <= tdi_s2;
      end
      if (cap_dr && ir == `TAP_INS_IDCODE) begin
        code_sh <= id_code;
      end else if (cap_dr && ir == `TAP_INS_USERCODE) begin
        code_sh <= USER_CODE;
      end else if (sh_dr && ins_code) begin
        code_sh <= {tdi_s2, code_sh[`TAP_CODE_LEN-1:1]};
      end
    end
  end

  // Standards may be loaded in any device phase; no configuration gate here.
  always @(posedge ref_clk) begin
    if (reset) begin
      iostd_sh <= {IOSTD_LEN{1'b0}};
      iostd_cfg <= {IOSTD_LEN{1'b0}};
    end else begin
      if (cap_dr && ins_iostd) begin
        iostd_sh <= iostd_cfg;
      end else if (sh_dr && ins_iostd) begin
        iostd_sh <= {tdi_s2, iostd_sh[IOSTD_LEN-1:1]};
      end
      if (upd_dr && ins_iostd) begin
        iostd_cfg <= iostd_sh;
      end
    end
  end

  // Configuration bits leave as bytes, first shifted bit in bit zero.
  always @(posedge ref_clk) begin
    if (reset) begin
      cfg_sh <= 8'h00;
      cfg_cnt <= 3'd0;
      cfg_byte <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else begin
      cfg_byte_valid <= 1'b0;
      if (cap_dr && ins_cfg) begin
        cfg_cnt <= 3'd0;
      end else if (sh_dr && ins_cfg) begin
        cfg_sh <= {tdi_s2, cfg_sh[7:1]};
        cfg_cnt <= cfg_cnt + 3'd1;
        if (cfg_cnt == 3'd7) begin
          cfg_byte <= {tdi_s2, cfg_sh[7:1]};
          cfg_byte_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Configuration control
  // ----------------------------------------
  // The request pin is only read, never driven, so the emulated pulse leaves it alone.
  always @(posedge ref_clk) begin
    if (reset) begin
      config_restart <= 1'b0;
      config_abort <= 1'b0;
    end else begin
      config_restart <= (~req_s2 & req_s3)
        | (upd_ir && ir_sh == `TAP_INS_RECONFIG_PULSE);
      config_abort <= upd_ir && ir_sh == `TAP_INS_CONFIG_IO && config_busy;
    end
  end

  // ----------------------------------------
  // Analyzer access
  // ----------------------------------------
  // Analyzer strobes follow the scan steps one-for-one while selected.
  always @(posedge ref_clk) begin
    if (reset) begin
      analyzer_sel <= 1'b0;
      analyzer_tdi <= 1'b0;
      analyzer_capture <= 1'b0;
      analyzer_shift <= 1'b0;
      analyzer_update <= 1'b0;
    end else begin
      analyzer_sel <= ins_anl;
      analyzer_tdi <= tdi_s2;
      analyzer_capture <= cap_dr & ins_anl;
      analyzer_shift <= sh_dr & ins_anl;
      analyzer_update <= upd_dr & ins_anl;
    end
  end

  // ----------------------------------------
  // Test data out
  // ----------------------------------------
  reg dr_bit;

  // Unlisted codes fall to the bypass bit.
  always @* begin
    if (ins_bsr) begin
      dr_bit = bsr_sh[0];
    end else if (ins_code) begin
      dr_bit = code_sh[0];
    end else if (ins_iostd) begin
      dr_bit = iostd_sh[0];
    end else if (ins_cfg) begin
      dr_bit = cfg_sh[0];
    end else if (ins_anl) begin
      dr_bit = analyzer_tdo;
    end else begin
      dr_bit = bypass;
    end
  end

  // TDO changes on the falling edge so the next device samples it stable.
  always @(posedge ref_clk) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (state == `TAP_ST_SH_DR) | (state == `TAP_ST_SH_IR);
      tdo <= (state == `TAP_ST_SH_IR) ? ir_sh[0] : dr_bit;
    end
  end

endmodule // tap_scan_port

//--- tap_checker_properties.sv
`timescale 1ns/1ps
// ------
// Port checks
// ------
module tap_checker #(
  parameter IO_NUM = 4
) (
  input wire ref_clk,
  input wire reset,
  input wire tck,
  input wire tdo,
  input wire tdo_oe,
  input wire [IO_NUM-1:0] keep_en,
  input wire [IO_NUM-1:0] pin_oe,
  input wire [IO_NUM-1:0] pin_keep,
  input wire config_request_pin_n,
  input wire config_busy,
  input wire config_restart,
  input wire config_abort,
  input wire cfg_byte_valid
);
  // Everything here lives in the system clock domain.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A pin request must show within the synchroniser delay.
  sequence req_fall;
    $fell(config_request_pin_n);
  endsequence
  sequence restart_soon;
    ##[1:6] config_restart;
  endsequence
  reset_clears_a:
    assert property ($fell(reset) |-> !tdo_oe && !config_restart && pin_oe == '0)
    else $error("outputs not cleared by reset");
  pin_restart_a:
    assert property (req_fall |-> restart_soon)
    else $error("request pin fall gave no restart");
  restart_pulse_a:
    assert property (config_restart |=> !config_restart)
    else $error("restart longer than one cycle");
  abort_pulse_a:
    assert property (config_abort |=> !config_abort)
    else $error("abort longer than one cycle");
  abort_busy_a:
    assert property (config_abort |-> $past(config_busy, 2))
    else $error("abort without configuration in progress");
  keep_enabled_a:
    assert property ((pin_keep & ~(keep_en | $past(keep_en) | $past(keep_en, 2))) == '0)
    else $error("hold active on a pin without it enabled");
  keep_floats_a:
    assert property ((pin_keep & pin_oe) == '0)
    else $error("held pin also driven");
  byte_pulse_a:
    assert property (cfg_byte_valid |=> !cfg_byte_valid)
    else $error("byte strobe longer than one cycle");
  tdo_edge_a:
    assert property (($changed(tdo) || $changed(tdo_oe)) |-> !$past(tck) && !$past(tck, 2))
    else $error("scan output moved outside a low test clock");
endmodule // tap_checker

bind tap_scan_port tap_checker #(.IO_NUM(IO_NUM)) tap_checker_i (
  .ref_clk(ref_clk), .reset(reset), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .keep_en(keep_en), .pin_oe(pin_oe), .pin_keep(pin_keep),
  .config_request_pin_n(config_request_pin_n), .config_busy(config_busy),
  .config_restart(config_restart), .config_abort(config_abort),
  .cfg_byte_valid(cfg_byte_valid));

//--- tap_ctl_model.sv
`timescale 1ns/1ps
// ------
// Test controller model
// ------
module tap_ctl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire tdo
);
  // The test clock rests low between frames; only the tasks pulse it.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One period; tdo is read just before the rise, long after the fall moved it.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  // Five high mode bits reach reset, one low bit parks in idle.
  task automatic go_idle();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Shifts n bits LSB first through the chosen path, idle to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule // tap_ctl_model

//--- tb_top.sv
`timescale 1ns/1ps
`include "tap_scan_map.vh"
module tb_top;
  // ------
  // Clock, stimulus and monitors
  // ------
  localparam logic [31:0] UCODE = 32'h5a5a_c3c3;
  localparam logic [31:0] IDV = {4'h3, 16'h0abc, 11'h2d1, 1'b1};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] keep_en = 4'h0;
  logic [3:0] core_oe = 4'h0;
  logic [3:0] pin_lvl = 4'h6;
  logic anl_out = 1'b1;
  logic req_n = 1'b1;
  logic busy = 1'b0;
  wire tck, tms, tdi, tdo, restart, abort, bval;
  wire [3:0] pin_oe, pin_keep, pin_drv;
  wire [31:0] iostd;
  wire [7:0] cbyte;
  logic [31:0] got;
  logic [7:0] last_byte;
  int n_restart, n_abort, n_valid, err_total, samples_checked;
  always #2.5 ref_clk = ~ref_clk;
  tap_scan_port #(.BSR_LEN(12), .IO_NUM(4), .IOSTD_LEN(32), .USER_CODE(UCODE), .ID_VERSION(4'h3),
    .ID_PART(16'h0abc), .ID_MAKER(11'h2d1)) tap_scan_port_i ( // Arbitrary id values.
    .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(), .pin_in(pin_lvl), .core_out(4'h9), .core_oe(core_oe), .keep_en(keep_en),
    .pin_out(pin_drv), .pin_oe(pin_oe), .pin_keep(pin_keep), .config_request_pin_n(req_n),
    .config_busy(busy), .config_restart(restart), .config_abort(abort),
    .cfg_byte(cbyte), .cfg_byte_valid(bval), .iostd_cfg(iostd), .analyzer_tdo(anl_out),
    .analyzer_sel(), .analyzer_tdi(), .analyzer_capture(), .analyzer_shift(),
    .analyzer_update());
  tap_ctl_model tap_ctl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // Strobes last one cycle, so they are counted rather than polled.
  always @(posedge ref_clk) begin
    if (restart) n_restart++;
    if (abort) n_abort++;
    if (bval) begin
      n_valid++;
      last_byte = cbyte;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load_ir(input logic [9:0] code);
    tap_ctl_model_i.scan(1'b1, 10, {22'h0, code}, got);
    chk("ir capture", {22'h0, `TAP_IR_CAPTURE}, got);
    repeat (12) @(posedge ref_clk);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_ident();
    tap_ctl_model_i.go_idle();
    tap_ctl_model_i.scan(1'b0, 32, 32'h0, got);
    chk("idcode", IDV, got);
    load_ir(`TAP_INS_USERCODE);
    tap_ctl_model_i.scan(1'b0, 32, 32'h0, got);
    chk("usercode", UCODE, got);
    $display("ident test done");
  endtask
  // A listed and an unlisted code must both give a one-bit delay.
  task automatic t_bypass();
    logic [9:0] codes [2] = '{`TAP_INS_BYPASS, 10'h155};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      tap_ctl_model_i.scan(1'b0, 8, 32'hb6, got);
      chk("bypass", 32'h6c, got);
    end
    $display("bypass test done");
  endtask
  // Core wants to drive all pins; test modes must float them instead.
  task automatic t_float();
    logic [9:0] codes [2] = '{`TAP_INS_HIGHZ, `TAP_INS_CLAMP};
    @(posedge ref_clk);
    keep_en <= 4'h5;
    core_oe <= 4'hf;
    foreach (codes[k]) begin
      load_ir(codes[k]);
      chk("pin_oe", 32'h0, {28'h0, pin_oe});
      chk("pin_keep", 32'h5, {28'h0, pin_keep});
      chk("pin_out", (k == 0) ? 32'h9 : 32'h0, {28'h0, pin_drv});
    end
    $display("float test done");
  endtask
  // A preload under sample must leave the pins alone; external test then drives them.
  task automatic t_extest();
    load_ir(`TAP_INS_SAMPLE);
    tap_ctl_model_i.scan(1'b0, 12, 32'h3a0, got);
    chk("sample capture", 32'hf96, got);
    chk("sample pin_out", 32'h9, {28'h0, pin_drv});
    pin_lvl <= 4'hc;
    load_ir(`TAP_INS_EXTEST);
    chk("extest pin_out", 32'ha, {28'h0, pin_drv});
    chk("extest pin_oe", 32'h3, {28'h0, pin_oe});
    chk("extest pin_keep", 32'h4, {28'h0, pin_keep});
    tap_ctl_model_i.scan(1'b0, 12, 32'h3a0, got);
    chk("extest capture", 32'h3ac, got);
    $display("extest test done");
  endtask
  task automatic t_config();
    load_ir(`TAP_INS_RECONFIG_PULSE);
    chk("restart count", 32'd1, n_restart);
    @(posedge ref_clk);
    req_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    req_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("restart count", 32'd2, n_restart);
    busy <= 1'b1;
    load_ir(`TAP_INS_CONFIG_IO);
    busy <= 1'b0;
    chk("abort count", 32'd1, n_abort);
    tap_ctl_model_i.scan(1'b0, 32, 32'h1357_9bdf, got);
    chk("iostd capture", 32'h0, got);
    chk("iostd", 32'h1357_9bdf, iostd);
    load_ir(`TAP_INS_CIRCUIT_RECONFIG);
    tap_ctl_model_i.scan(1'b0, 8, 32'ha5, got);
    repeat (12) @(posedge ref_clk);
    chk("byte count", 32'd1, n_valid);
    chk("byte", 32'ha5, {24'h0, last_byte});
    load_ir(`TAP_INS_ANALYZER);
    tap_ctl_model_i.scan(1'b0, 8, 32'h0, got);
    chk("analyzer", 32'hff, got);
    $display("config test done");
  endtask
  // ------
  // Sequence and verdict
  // ------
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The tests take well under 200 us; twice that means a hang.
  initial begin
    #400us;
    err_total++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_ident();
    t_bypass();
    t_float();
    t_extest();
    t_config();
    close_out();
  end
endmodule // tb_top
